/* File: src/pcstat_pkg.sv */
// Package with constants for the program counter and status register block
package pcstat_pkg;

  // Address widths and memory depth
  localparam int PC_WIDTH      = 13;
  localparam int PROG_AW       = 11;
  localparam int PROG_WORD     = 14;
  localparam int PROG_DEPTH    = 2048;
  localparam int DATA_AW       = 8;

  // Vectors
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] INT_VECTOR   = 13'h0004;
  localparam logic [12:0] PROG_TOP     = 13'h07ff;

  // Status register addresses, one per bank pair
  localparam logic [7:0] STATUS_ADDR_LO = 8'h03;
  localparam logic [7:0] STATUS_ADDR_HI = 8'h83;

  // Status register fields
  localparam int CARRY_BIT  = 0;
  localparam int NIBBLE_BIT = 1;
  localparam int ZERO_BIT   = 2;
  localparam int POWERDOWN_BIT = 3;
  localparam int TIMEOUT_BIT   = 4;
  localparam int BANK_LO    = 5;
  localparam int BANK_HI    = 6;
  localparam int IPAGE_BIT  = 7;

  // Status reset value: timeout and power-down set, rest clear
  localparam logic [7:0] STATUS_RESET = 8'h18;

  // Masks of bits by write behaviour
  localparam logic [7:0] FLAG_MASK     = 8'h07;
  localparam logic [7:0] LOCKED_MASK   = 8'h18;
  localparam logic [7:0] UPPER_MASK    = 8'he0;

  // Write kinds issued by the instruction logic
  typedef enum logic [1:0] {
    WR_NONE  = 2'b00,
    WR_DATA  = 2'b01,
    WR_CLEAR = 2'b10
  } write_kind_t;

  // True when a data address selects the status register
  function automatic logic is_status_addr(input logic [7:0] addr);
    is_status_addr = (addr == STATUS_ADDR_LO) || (addr == STATUS_ADDR_HI);
  endfunction

endpackage

/* File: src/prog_rom.sv */
// Implemented program memory, 2K words, wrapped by dropping upper PC bits
`timescale 1ns/1ps
`default_nettype none
module prog_rom
  import pcstat_pkg::*;
(
  input  wire logic                  mclk_i,     // Core clock
  input  wire logic [PC_WIDTH-1:0]   addr_i,     // Full program counter
  input  wire logic                  load_en_i,  // Program load strobe
  input  wire logic [PROG_AW-1:0]    load_addr_i,// Program load address
  input  wire logic [PROG_WORD-1:0]  load_data_i,// Program load word
  output logic      [PROG_WORD-1:0]  data_o      // Fetched word, registered
);

  // Storage array
  logic [PROG_WORD-1:0] mem [PROG_DEPTH];

  // Upper two address bits ignored, giving wraparound
  logic [PROG_AW-1:0] idx;
  assign idx = addr_i[PROG_AW-1:0];

  // Synchronous read and load port
  always_ff @(posedge mclk_i) begin
    if (load_en_i) begin
      mem[load_addr_i] <= load_data_i;
    end
    data_o <= mem[idx];
  end

endmodule
`default_nettype wire

/* File: src/pc_status_core.sv */
// Program counter with fetch addressing, and the arithmetic status register
// Notes on behaviour
// - Thirteen-bit counter spans 8K fourteen-bit words.
// - Only 2K implemented; higher fetches wrap.
// - Reset starts at 0000h; interrupt loads 0004h.
// - Separate program and data buses, concurrent.
// - Status holds flags, reset cause, bank.
// - Status answers at 03h and 83h.
// - Flag-updating writes leave flags to logic.
// - Timeout and power-down ignore instruction writes.
// - Clear zeroes upper bits, sets zero flag.
// - Subtraction flags mean borrow, digit borrow.
`timescale 1ns/1ps
`default_nettype none
module pc_status_core
  import pcstat_pkg::*;
(
  input  wire logic                  mclk_i,        // Core clock, 40 MHz
  input  wire logic                  reset_i,       // Synchronous reset
  // Program counter control
  input  wire logic                  pc_step_i,     // Advance to next word
  input  wire logic                  pc_jump_i,     // Load branch target
  input  wire logic [PC_WIDTH-1:0]   pc_target_i,   // Branch target
  input  wire logic                  int_take_i,    // Interrupt taken
  // Program memory load port
  input  wire logic                  load_en_i,     // Load strobe
  input  wire logic [PROG_AW-1:0]    load_addr_i,   // Load address
  input  wire logic [PROG_WORD-1:0]  load_data_i,   // Load word
  // Data bus
  input  wire logic [DATA_AW-1:0]    data_addr_i,   // Data address
  input  wire write_kind_t           data_wr_i,     // Write kind
  input  wire logic [7:0]            data_wdata_i,  // Write data
  // Flag logic from the arithmetic unit
  input  wire logic                  flag_upd_i,    // Instruction updates flags
  input  wire logic [2:0]            flag_mask_i,   // Which flags it updates
  input  wire logic                  alu_zero_i,    // Zero result
  input  wire logic                  alu_nibble_i,  // Nibble carry or borrow
  input  wire logic                  alu_carry_i,   // Carry or borrow
  input  wire logic                  alu_sub_i,     // Operation is a subtract
  // Reset-cause logic
  input  wire logic                  timeout_evt_i, // Watchdog timeout event
  input  wire logic                  sleep_evt_i,   // Sleep entered
  input  wire logic                  cause_clr_i,   // Watchdog clear / restart
  // Outputs
  output logic      [PC_WIDTH-1:0]   pc_o,          // Program counter
  output logic      [PROG_WORD-1:0]  instr_o,       // Fetched word
  output logic      [7:0]            status_o,      // Status register
  output logic      [7:0]            data_rdata_o,  // Data read, registered
  output logic                       data_hit_o     // Status selected, registered
);

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  logic [PC_WIDTH-1:0] pc_reg;   // Current fetch address
  logic [PC_WIDTH-1:0] pc_next;  // Next fetch address

  // Next address: interrupt beats jump beats step
  always_comb begin
    pc_next = pc_reg;
    if (int_take_i) begin
      pc_next = INT_VECTOR;
    end else if (pc_jump_i) begin
      pc_next = pc_target_i;
    end else if (pc_step_i) begin
      pc_next = PC_WIDTH'(pc_reg + 13'h0001);
    end
  end

  // Counter register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pc_reg <= RESET_VECTOR;
    end else begin
      pc_reg <= pc_next;
    end
  end

  assign pc_o = pc_reg;

  // Program memory on its own bus, runs alongside data access
  prog_rom u_rom (
    .mclk_i      (mclk_i),
    .addr_i      (pc_reg),
    .load_en_i   (load_en_i),
    .load_addr_i (load_addr_i),
    .load_data_i (load_data_i),
    .data_o      (instr_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status register

  logic [7:0] status_reg;   // Flags, reset cause, bank bits
  logic [7:0] status_next;  // Next status value
  logic       sel;          // Data address selects status
  logic [7:0] flag_val;     // Flags produced by the arithmetic unit
  logic [7:0] keep_mask;    // Bits a data write may not touch
  logic [7:0] rdata_next;   // Next read data
  logic       hit_next;     // Next hit flag

  // Both bank images decode to the same register
  assign sel = is_status_addr(data_addr_i);

  // Carry and nibble inputs already mean borrow during subtracts
  assign flag_val = {5'h00, alu_zero_i, alu_nibble_i, alu_carry_i};

  // Data writes never reach locked bits, nor flags being updated
  assign keep_mask = LOCKED_MASK
                   | (flag_upd_i ? {5'h00, flag_mask_i} : 8'h00);

  // Next status: data write, then flag logic, then reset-cause events
  always_comb begin
    status_next = status_reg;
    if (sel && data_wr_i == WR_DATA) begin
      // Any instruction may target status
      status_next = (status_reg & keep_mask) | (data_wdata_i & ~keep_mask);
    end else if (sel && data_wr_i == WR_CLEAR) begin
      // Clear: upper bits zero, zero flag set
      status_next = status_reg & ~UPPER_MASK;
      status_next[ZERO_BIT] = 1'b1;
    end
    // Flag logic overrides any data write to the flags
    if (flag_upd_i) begin
      for (int i = 0; i < 3; i++) begin
        if (flag_mask_i[i]) begin
          status_next[i] = flag_val[i];
        end
      end
    end
    // Only device logic moves timeout and power-down
    if (cause_clr_i) begin
      status_next[TIMEOUT_BIT]   = 1'b1;
      status_next[POWERDOWN_BIT] = 1'b1;
    end
    if (timeout_evt_i) begin
      status_next[TIMEOUT_BIT] = 1'b0;
    end
    if (sleep_evt_i) begin
      status_next[POWERDOWN_BIT] = 1'b0;
    end
  end

  // Read path, registered
  always_comb begin
    hit_next   = sel;
    rdata_next = sel ? status_next : 8'h00;
  end

  // Status and read registers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      status_reg   <= STATUS_RESET;
      data_rdata_o <= 8'h00;
      data_hit_o   <= 1'b0;
    end else begin
      status_reg   <= status_next;
      data_rdata_o <= rdata_next;
      data_hit_o   <= hit_next;
    end
  end

  assign status_o = status_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_pc_reset_vec: assert property (@(posedge mclk_i)
    reset_i |=> pc_reg == RESET_VECTOR)
    else $error("PC not at reset vector after reset");

  a_pc_int_vec: assert property (@(posedge mclk_i) disable iff (reset_i)
    int_take_i |=> pc_reg == INT_VECTOR)
    else $error("PC not at interrupt vector");

  a_pc_step_wrap: assert property (@(posedge mclk_i) disable iff (reset_i)
    (pc_step_i && !pc_jump_i && !int_take_i) |=>
      pc_reg == PC_WIDTH'($past(pc_reg) + 13'h0001))
    else $error("PC step wrong");

  // Fetch index is the counter modulo the implemented depth
  a_rom_wrap_idx: assert property (@(posedge mclk_i)
    u_rom.idx == PROG_AW'(pc_reg % PROG_DEPTH))
    else $error("Program index not wrapped");

  a_locked_bits: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!timeout_evt_i && !sleep_evt_i && !cause_clr_i) |=>
      status_reg[TIMEOUT_BIT:POWERDOWN_BIT] == $past(status_reg[TIMEOUT_BIT:POWERDOWN_BIT]))
    else $error("Locked bits changed by write");

  a_flag_override: assert property (@(posedge mclk_i) disable iff (reset_i)
    (flag_upd_i && flag_mask_i[ZERO_BIT]) |=>
      status_reg[ZERO_BIT] == $past(alu_zero_i))
    else $error("Zero flag not from flag logic");

  a_clear_status: assert property (@(posedge mclk_i) disable iff (reset_i)
    (sel && data_wr_i == WR_CLEAR && !flag_upd_i) |=>
      status_reg[7:5] == 3'h0 && status_reg[ZERO_BIT])
    else $error("Clear did not set status as expected");

  a_dual_address: assert property (@(posedge mclk_i) disable iff (reset_i)
    is_status_addr(data_addr_i) |=> data_hit_o && data_rdata_o == status_reg)
    else $error("Status not reachable at both addresses");

  a_sub_borrow: assert property (@(posedge mclk_i) disable iff (reset_i)
    (flag_upd_i && alu_sub_i && flag_mask_i[CARRY_BIT]) |=>
      status_reg[CARRY_BIT] == $past(alu_carry_i))
    else $error("Borrow flag wrong");

  // Main scenarios: interrupt, wrapped fetch, clear, upper image, subtract
  c_int_taken:   cover property (@(posedge mclk_i) int_take_i);
  c_pc_wrap:     cover property (@(posedge mclk_i) pc_reg > PROG_TOP);
  c_clear_write: cover property (@(posedge mclk_i) sel && data_wr_i == WR_CLEAR);
  c_hi_image:    cover property (@(posedge mclk_i)
    data_addr_i == STATUS_ADDR_HI && data_wr_i == WR_DATA);
  c_sub_flags:   cover property (@(posedge mclk_i) flag_upd_i && alu_sub_i);

endmodule
`default_nettype wire

/* File: test/pc_status_core_tb.sv */
// Self-checking testbench for the program counter and status register core
`timescale 1ns/1ps
`default_nettype none
module pc_status_core_tb;
  import pcstat_pkg::*;

  logic                 mclk_i = 1'b0;       // Core clock
  logic                 reset_i = 1'b1;      // Synchronous reset
  logic                 pc_step_i = 1'b0;    // Step request
  logic                 pc_jump_i = 1'b0;    // Jump request
  logic [PC_WIDTH-1:0]  pc_target_i = '0;    // Jump target
  logic                 int_take_i = 1'b0;   // Interrupt taken
  logic                 load_en_i = 1'b0;    // Program load strobe
  logic [PROG_AW-1:0]   load_addr_i = '0;    // Program load address
  logic [PROG_WORD-1:0] load_data_i = '0;    // Program load word
  logic [DATA_AW-1:0]   data_addr_i = '0;    // Data address
  write_kind_t          data_wr_i = WR_NONE; // Write kind
  logic [7:0]           data_wdata_i = '0;   // Write data
  logic                 flag_upd_i = 1'b0;   // Flag update
  logic [2:0]           flag_mask_i = '0;    // Flags touched: zero, nibble, carry
  logic                 alu_zero_i = 1'b0;   // Zero result
  logic                 alu_nibble_i = 1'b0; // Digit carry or borrow
  logic                 alu_carry_i = 1'b0;  // Carry or borrow
  logic                 alu_sub_i = 1'b0;    // Subtract marker
  logic                 timeout_evt_i = 1'b0; // Timeout event
  logic                 sleep_evt_i = 1'b0;  // Sleep event
  logic                 cause_clr_i = 1'b0;  // Cause restart
  logic [PC_WIDTH-1:0]  pc_o;                // Program counter
  logic [PROG_WORD-1:0] instr_o;             // Fetched word
  logic [7:0]           status_o;            // Status register
  logic [7:0]           data_rdata_o;        // Read data
  logic                 data_hit_o;          // Status selected
  int                   bad_count = 0;       // Mismatches
  int                   num_checks = 0;      // Comparisons

  pc_status_core i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .pc_step_i(pc_step_i),
    .pc_jump_i(pc_jump_i), .pc_target_i(pc_target_i), .int_take_i(int_take_i),
    .load_en_i(load_en_i), .load_addr_i(load_addr_i), .load_data_i(load_data_i),
    .data_addr_i(data_addr_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
    .flag_upd_i(flag_upd_i), .flag_mask_i(flag_mask_i), .alu_zero_i(alu_zero_i),
    .alu_nibble_i(alu_nibble_i), .alu_carry_i(alu_carry_i), .alu_sub_i(alu_sub_i),
    .timeout_evt_i(timeout_evt_i), .sleep_evt_i(sleep_evt_i), .cause_clr_i(cause_clr_i),
    .pc_o(pc_o), .instr_o(instr_o), .status_o(status_o), .data_rdata_o(data_rdata_o),
    .data_hit_o(data_hit_o));

  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One status bus access, then one idle edge so that back-to-back calls
  // never move a strobe twice in one time step; outputs settled on return
  task automatic wr(input logic [7:0] a, input write_kind_t k, input logic [7:0] d);
    data_addr_i = a;
    data_wr_i = k;
    data_wdata_i = d;
    @(negedge mclk_i);
    data_wr_i = WR_NONE;
    flag_upd_i = 1'b0;
    @(negedge mclk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check(16'(pc_o), 16'(RESET_VECTOR));
    check(16'(status_o), 16'h0018);
  endtask

  task automatic t_pc();
    // Load a word at low address 005h, then fetch it from 805h
    load_en_i = 1'b1;
    load_addr_i = 11'h005;
    load_data_i = 14'h2a5c;
    pc_step_i = 1'b1;
    @(negedge mclk_i);
    load_en_i = 1'b0;
    pc_step_i = 1'b0;
    check(16'(pc_o), 16'h0001);
    int_take_i = 1'b1;
    pc_jump_i = 1'b1;
    pc_target_i = 13'h0123;
    @(negedge mclk_i);
    int_take_i = 1'b0;
    check(16'(pc_o), 16'(INT_VECTOR));
    pc_target_i = 13'h1fff;
    @(negedge mclk_i);
    pc_jump_i = 1'b0;
    pc_step_i = 1'b1;
    check(16'(pc_o), 16'h1fff);
    @(negedge mclk_i);
    pc_step_i = 1'b0;
    check(16'(pc_o), 16'h0000);
    pc_jump_i = 1'b1;
    pc_target_i = 13'h0805;
    // Data write in the same cycle as the jump to 805h; the fetch from 805h follows
    wr(STATUS_ADDR_LO, WR_DATA, 8'h01);
    pc_jump_i = 1'b0;
    check(16'(status_o), 16'h0019);
    @(negedge mclk_i);
    check(16'(instr_o), 16'h2a5c);
  endtask

  task automatic t_status();
    wr(STATUS_ADDR_HI, WR_DATA, 8'h27);
    check(16'(status_o), 16'h003f);
    check(16'({data_hit_o, data_rdata_o}), 16'h013f);
    wr(8'h13, WR_DATA, 8'h00);
    check(16'({data_hit_o, status_o}), 16'h003f);
    flag_upd_i = 1'b1;
    flag_mask_i = 3'b111;
    {alu_zero_i, alu_nibble_i, alu_carry_i} = 3'b101;
    wr(STATUS_ADDR_LO, WR_DATA, 8'h02);
    check(16'(status_o), 16'h001d);
    // Subtract with borrow: flags taken as given, no inversion
    flag_upd_i = 1'b1;
    alu_sub_i = 1'b1;
    {alu_zero_i, alu_nibble_i, alu_carry_i} = 3'b010;
    wr(STATUS_ADDR_LO, WR_DATA, 8'h3d);
    alu_sub_i = 1'b0;
    check(16'(status_o), 16'h003a);
    wr(STATUS_ADDR_LO, WR_DATA, 8'h23);
    check(16'(status_o), 16'h003b);
    wr(STATUS_ADDR_HI, WR_CLEAR, 8'h00);
    check(16'(status_o), 16'h001f);
  endtask

  task automatic t_cause();
    timeout_evt_i = 1'b1;
    @(negedge mclk_i);
    timeout_evt_i = 1'b0;
    sleep_evt_i = 1'b1;
    check(16'(status_o), 16'h000f);
    @(negedge mclk_i);
    sleep_evt_i = 1'b0;
    check(16'(status_o), 16'h0007);
    wr(STATUS_ADDR_LO, WR_DATA, 8'h18);
    check(16'(status_o), 16'h0000);
    cause_clr_i = 1'b1;
    @(negedge mclk_i);
    cause_clr_i = 1'b0;
    check(16'(status_o), 16'h0018);
  endtask

  // Second reset in mid-run, taken from a non-zero fetch address
  task automatic t_rerun();
    reset_i = 1'b1;
    @(negedge mclk_i);
    reset_i = 1'b0;
    check(16'(pc_o), 16'(RESET_VECTOR));
    check(16'(status_o), 16'h0018);
    check(16'({data_hit_o, data_rdata_o}), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and hang guard
  initial begin
    repeat (5) @(negedge mclk_i);
    reset_i = 1'b0;
    t_reset();
    t_pc();
    t_status();
    t_cause();
    t_rerun();
    print_verdict();
  end

  initial begin
    #20us;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
